/* rtl/uef_pkg.sv */
// Purpose: shared constants and types for the enhanced flow and reset block
// Assumes: four channels, 32-bit avalon-mm slave with byte addresses
// Notes: global offsets are byte addresses; channel register indices count 32-bit words
package uef_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int UEF_NCH = 4;
  localparam int UEF_AW = 9;
  localparam int UEF_NEV = 12;

  // ----------------------------------------
  // channel register offsets (inside a channel window)
  // ----------------------------------------
  localparam logic [3:0] UEF_IDX_IER = 4'h0;
  localparam logic [3:0] UEF_IDX_ISR = 4'h1;
  localparam logic [3:0] UEF_IDX_FCR = 4'h2;
  localparam logic [3:0] UEF_IDX_LCR = 4'h3;
  localparam logic [3:0] UEF_IDX_MCR = 4'h4;
  localparam logic [3:0] UEF_IDX_LSR = 4'h5;
  localparam logic [3:0] UEF_IDX_MSR = 4'h6;
  localparam logic [3:0] UEF_IDX_EFR = 4'h7;
  localparam logic [3:0] UEF_IDX_RESUME_CHAR_FIRST = 4'h8;
  localparam logic [3:0] UEF_IDX_RESUME_CHAR_SECOND = 4'h9;
  localparam logic [3:0] UEF_IDX_PAUSE_CHAR_FIRST = 4'ha;
  localparam logic [3:0] UEF_IDX_PAUSE_CHAR_SECOND = 4'hb;
  localparam int UEF_CH_SHIFT = 6;

  // ----------------------------------------
  // global interrupt registers
  // ----------------------------------------
  localparam logic [8:0] UEF_OFS_IRQ_STAT = 9'h100;
  localparam logic [8:0] UEF_OFS_IRQ_CLR = 9'h104;
  localparam logic [8:0] UEF_OFS_IRQ_EN = 9'h108;
  localparam int UEF_EV_SPECIAL = 0;
  localparam int UEF_EV_PAUSE = 4;
  localparam int UEF_EV_RESUME = 8;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int UEF_EFR_SPECIAL = 5;
  localparam int UEF_EFR_ENH = 4;
  localparam int UEF_MCR_ENH_BIT = 6;
  localparam int UEF_LCR_BREAK = 6;
  localparam int UEF_MCR_RTS = 1;
  localparam int UEF_MCR_DTR = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] UEF_RST_CTRL = 8'h00;
  localparam logic [7:0] UEF_RST_ISR = 8'h01;
  localparam logic [7:0] UEF_RST_LSR = 8'h60;
  localparam logic [3:0] UEF_RST_MSR_DELTA = 4'h0;

  // ----------------------------------------
  // flow control selections
  // ----------------------------------------
  typedef enum logic [1:0] {
    UEF_RX_NONE = 2'b00,
    UEF_RX_SECOND = 2'b01,
    UEF_RX_FIRST = 2'b10,
    UEF_RX_BOTH = 2'b11
  } uef_rx_mode_t;

endpackage : uef_pkg

/* rtl/uef_match.sv */
// Purpose: per-channel receive character comparator for flow control
// Assumes: one received character per i_rx_valid pulse
// Notes: pulses come one cycle after the character
`timescale 1ns/1ps
module uef_match (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic [1:0] i_mode,
  input wire logic i_special_en,
  input wire logic [7:0] i_resume_char_first,
  input wire logic [7:0] i_resume_char_second,
  input wire logic [7:0] i_pause_char_first,
  input wire logic [7:0] i_pause_char_second,
  output logic o_pause,
  output logic o_resume,
  output logic o_special
);

  typedef struct packed {
    logic seen_on1;
    logic seen_off1;
    logic pause;
    logic resume;
    logic special;
  } uef_match_st_t;

  uef_match_st_t st_r;
  uef_match_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pause = 1'b0;
    st_nxt.resume = 1'b0;
    st_nxt.special = 1'b0;
    if (i_rx_valid) begin
      // bit 0 of every character register meets bit 0 of the received character
      st_nxt.special = i_special_en && (i_rx_data == i_pause_char_second);
      st_nxt.seen_on1 = 1'b0;
      st_nxt.seen_off1 = 1'b0;
      case (i_mode)
        uef_pkg::UEF_RX_FIRST: begin
          st_nxt.pause = (i_rx_data == i_pause_char_first);
          st_nxt.resume = (i_rx_data == i_resume_char_first);
        end
        uef_pkg::UEF_RX_SECOND: begin
          st_nxt.pause = (i_rx_data == i_pause_char_second);
          st_nxt.resume = (i_rx_data == i_resume_char_second);
        end
        uef_pkg::UEF_RX_BOTH: begin
          st_nxt.pause = st_r.seen_off1 && (i_rx_data == i_pause_char_second);
          st_nxt.resume = st_r.seen_on1 && (i_rx_data == i_resume_char_second);
          st_nxt.seen_on1 = (i_rx_data == i_resume_char_first);
          st_nxt.seen_off1 = (i_rx_data == i_pause_char_first);
        end
        default: begin
          st_nxt.pause = 1'b0;
        end
      endcase
    end
    if (i_srst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  assign o_pause = st_r.pause;
  assign o_resume = st_r.resume;
  assign o_special = st_r.special;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  first_pair_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rx_valid && i_mode == 2'b10 && i_rx_data == i_pause_char_first |=> o_pause)
    else $error("first pause character not detected");

  seq_pause_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rx_valid && i_mode == 2'b11 && i_rx_data == i_pause_char_first) ##1
    (i_rx_valid && i_mode == 2'b11 && i_rx_data == i_pause_char_second) |=> o_pause)
    else $error("pause sequence not detected");

  special_hit_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_special |-> $past(i_special_en) && $past(i_rx_valid)
      && $past(i_rx_data) == $past(i_pause_char_second))
    else $error("special flag without matching character");

  seq_cov_c: cover property (@(posedge i_clk) disable iff (i_srst)
    i_mode == 2'b11 && o_resume);

endmodule : uef_match

/* rtl/uef_top.sv */
// Purpose: four-channel enhanced feature, flow selection and reset state of a uart
// Assumes: avalon-mm slave, one wait cycle per access, inputs synchronous to i_clk
// Notes: channel windows at 0x00/0x40/0x80/0xc0, interrupt block at 0x100
// How it works
// - special detect on: match second pause char, still store, set status bit four
// - character register bit zero compares with received character bit zero
// - upper enable bits, status bits five/four, control bit six need enhanced bit
// - clearing the enhanced bit freezes those bits against ordinary writes
// - transmit flow selection from bits three and two
// - receive compare from bits one and zero: none, second pair, first pair
// - both receive bits set: match first then second pause or resume characters
// - reset clears enable, line, modem, fifo control and enhanced registers
// - reset sets status bit zero and clears status bits seven to one
// - reset clears line status bits seven and four..zero, sets six and five
// - reset clears modem change bits; upper modem bits follow live inputs
// - reset drives transmit, request, terminal-ready and receive-ready high, tx-ready low
`timescale 1ns/1ps
module uef_top #(
  parameter int NCH = uef_pkg::UEF_NCH
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [8:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  input wire logic [3:0] i_rx_valid,
  input wire logic [3:0][7:0] i_rx_data,
  output logic [3:0] o_rx_store,
  output logic [3:0][7:0] o_rx_data,
  output logic [3:0][1:0] o_tx_flow_sel,
  output logic [3:0] o_tx_paused,
  input wire logic [3:0] i_tx_bit,
  input wire logic [3:0] i_thr_empty,
  input wire logic [3:0] i_tsr_empty,
  input wire logic [3:0] i_rx_has_data,
  input wire logic [3:0] i_tx_fifo_full,
  input wire logic [3:0][3:0] i_modem_n,
  output logic [3:0] o_serial_out,
  output logic [3:0] o_request_send_n,
  output logic [3:0] o_terminal_ready_n,
  output logic o_receive_dma_ready_n,
  output logic o_transmit_dma_ready_n
);

  typedef struct packed {
    logic [3:0][7:0] interrupt_enable_reg;
    logic [3:0][1:0] isr54;
    logic [3:0][7:0] fifo_control_reg;
    logic [3:0][7:0] line_control_reg;
    logic [3:0][7:0] modem_control_reg;
    logic [3:0][7:0] enhanced_feature_control;
    logic [3:0][7:0] resume_char_first;
    logic [3:0][7:0] resume_char_second;
    logic [3:0][7:0] pause_char_first;
    logic [3:0][7:0] pause_char_second;
    logic [3:0][3:0] msr_delta;
    logic [3:0][3:0] msr_prev;
    logic msr_primed;
    logic [3:0][1:0] lsr65;
    logic [3:0] lsr0;
    logic [3:0] tx_paused;
    logic [11:0] irq_stat;
    logic [11:0] irq_en;
    logic wait_n;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] ser;
    logic [3:0] rts_n;
    logic [3:0] dtr_n;
    logic receive_dma_ready_n;
    logic transmit_dma_ready_n;
    logic [3:0] rx_store;
    logic [3:0][7:0] rx_data;
  } uef_top_st_t;

  uef_top_st_t st_r;
  uef_top_st_t st_nxt;
  logic [3:0] m_pause;
  logic [3:0] m_resume;
  logic [3:0] m_special;

  // ----------------------------------------
  // address decode helpers
  // ----------------------------------------
  function automatic logic [1:0] addr_ch(input logic [8:0] a);
    return a[7:6];
  endfunction : addr_ch

  function automatic logic [3:0] addr_reg(input logic [8:0] a);
    return a[5:2];
  endfunction : addr_reg

  function automatic logic addr_is_chan(input logic [8:0] a);
    return !a[8] && a[1:0] == 2'b00;
  endfunction : addr_is_chan

  // ----------------------------------------
  // per-channel comparators
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    uef_match u_match (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_rx_valid(i_rx_valid[c]),
      .i_rx_data(i_rx_data[c]),
      .i_mode(st_r.enhanced_feature_control[c][1:0]),
      .i_special_en(st_r.enhanced_feature_control[c][uef_pkg::UEF_EFR_SPECIAL]),
      .i_resume_char_first(st_r.resume_char_first[c]),
      .i_resume_char_second(st_r.resume_char_second[c]),
      .i_pause_char_first(st_r.pause_char_first[c]),
      .i_pause_char_second(st_r.pause_char_second[c]),
      .o_pause(m_pause[c]),
      .o_resume(m_resume[c]),
      .o_special(m_special[c])
    );
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] ch;
    logic [3:0] ri;
    logic [3:0] live;
    logic [3:0] dlt;
    logic [7:0] wb;
    logic [11:0] ev;
    ch = addr_ch(i_avs_address);
    ri = addr_reg(i_avs_address);
    live = 4'h0;
    dlt = 4'h0;
    wb = i_avs_writedata[7:0];
    ev = 12'h000;
    st_nxt = st_r;

    // bus slave: wait one cycle, answer, then act at the edge the master samples
    if ((i_avs_read || i_avs_write) && !st_r.wait_n) begin
      st_nxt.wait_n = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (i_avs_read && addr_is_chan(i_avs_address)) begin
        case (ri)
          uef_pkg::UEF_IDX_IER: st_nxt.rdata[7:0] = st_r.interrupt_enable_reg[ch];
          uef_pkg::UEF_IDX_ISR: st_nxt.rdata[7:0] = {{2{st_r.fifo_control_reg[ch][0]}}, st_r.isr54[ch],
                                                     3'b000, !st_r.isr54[ch][0]};
          uef_pkg::UEF_IDX_FCR: st_nxt.rdata[7:0] = st_r.fifo_control_reg[ch];
          uef_pkg::UEF_IDX_LCR: st_nxt.rdata[7:0] = st_r.line_control_reg[ch];
          uef_pkg::UEF_IDX_MCR: st_nxt.rdata[7:0] = st_r.modem_control_reg[ch];
          uef_pkg::UEF_IDX_LSR: st_nxt.rdata[7:0] = {1'b0, st_r.lsr65[ch], 4'h0, st_r.lsr0[ch]};
          // upper modem bits read the live inputs, even straight after reset
          uef_pkg::UEF_IDX_MSR: st_nxt.rdata[7:0] = {~i_modem_n[ch], st_r.msr_delta[ch]};
          uef_pkg::UEF_IDX_EFR: st_nxt.rdata[7:0] = st_r.enhanced_feature_control[ch];
          uef_pkg::UEF_IDX_RESUME_CHAR_FIRST: st_nxt.rdata[7:0] = st_r.resume_char_first[ch];
          uef_pkg::UEF_IDX_RESUME_CHAR_SECOND: st_nxt.rdata[7:0] = st_r.resume_char_second[ch];
          uef_pkg::UEF_IDX_PAUSE_CHAR_FIRST: st_nxt.rdata[7:0] = st_r.pause_char_first[ch];
          uef_pkg::UEF_IDX_PAUSE_CHAR_SECOND: st_nxt.rdata[7:0] = st_r.pause_char_second[ch];
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end else if (i_avs_read && i_avs_address == uef_pkg::UEF_OFS_IRQ_STAT) begin
        st_nxt.rdata[11:0] = st_r.irq_stat;
      end else if (i_avs_read && i_avs_address == uef_pkg::UEF_OFS_IRQ_EN) begin
        st_nxt.rdata[11:0] = st_r.irq_en;
      end
    end else if ((i_avs_read || i_avs_write) && st_r.wait_n) begin
      st_nxt.wait_n = 1'b0;
      if (i_avs_write && addr_is_chan(i_avs_address)) begin
        case (ri)
          uef_pkg::UEF_IDX_IER: begin
            st_nxt.interrupt_enable_reg[ch][3:0] = wb[3:0];
            if (st_r.enhanced_feature_control[ch][uef_pkg::UEF_EFR_ENH]) begin
              st_nxt.interrupt_enable_reg[ch][7:4] = wb[7:4];
            end
          end
          uef_pkg::UEF_IDX_ISR: begin
            if (st_r.enhanced_feature_control[ch][uef_pkg::UEF_EFR_ENH]) begin
              st_nxt.isr54[ch] = {wb[5], wb[4]};
            end
          end
          uef_pkg::UEF_IDX_FCR: st_nxt.fifo_control_reg[ch] = wb;
          uef_pkg::UEF_IDX_LCR: st_nxt.line_control_reg[ch] = wb;
          uef_pkg::UEF_IDX_MCR: begin
            st_nxt.modem_control_reg[ch][5:0] = wb[5:0];
            st_nxt.modem_control_reg[ch][7] = wb[7];
            if (st_r.enhanced_feature_control[ch][uef_pkg::UEF_EFR_ENH]) begin
              st_nxt.modem_control_reg[ch][uef_pkg::UEF_MCR_ENH_BIT] = wb[6];
            end
          end
          uef_pkg::UEF_IDX_EFR: st_nxt.enhanced_feature_control[ch] = wb;
          uef_pkg::UEF_IDX_RESUME_CHAR_FIRST: st_nxt.resume_char_first[ch] = wb;
          uef_pkg::UEF_IDX_RESUME_CHAR_SECOND: st_nxt.resume_char_second[ch] = wb;
          uef_pkg::UEF_IDX_PAUSE_CHAR_FIRST: st_nxt.pause_char_first[ch] = wb;
          uef_pkg::UEF_IDX_PAUSE_CHAR_SECOND: st_nxt.pause_char_second[ch] = wb;
          default: st_nxt.wait_n = 1'b0;
        endcase
      end else if (i_avs_write && i_avs_address == uef_pkg::UEF_OFS_IRQ_CLR) begin
        st_nxt.irq_stat = st_r.irq_stat & ~i_avs_writedata[11:0];
      end else if (i_avs_write && i_avs_address == uef_pkg::UEF_OFS_IRQ_EN) begin
        st_nxt.irq_en = i_avs_writedata[11:0];
      end
      // read side effects: status bit four and the change bits clear once seen
      if (i_avs_read && addr_is_chan(i_avs_address) && ri == uef_pkg::UEF_IDX_ISR) begin
        st_nxt.isr54[ch][0] = 1'b0;
      end
      if (i_avs_read && addr_is_chan(i_avs_address) && ri == uef_pkg::UEF_IDX_MSR) begin
        st_nxt.msr_delta[ch] = 4'h0;
      end
    end else begin
      st_nxt.wait_n = 1'b0;
    end

    // channel logic; sets come after the clears so an event in a clear cycle survives
    st_nxt.msr_primed = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      live = ~i_modem_n[c];
      st_nxt.msr_prev[c] = live;
      // ring indicator flags only its trailing edge; the others flag any change
      dlt = st_r.msr_primed ? {live[3] ^ st_r.msr_prev[c][3], st_r.msr_prev[c][2] & ~live[2],
                               live[1:0] ^ st_r.msr_prev[c][1:0]} : 4'h0;
      st_nxt.msr_delta[c] = st_nxt.msr_delta[c] | dlt;
      if (m_special[c]) begin
        st_nxt.isr54[c][0] = 1'b1;
      end
      if (st_r.enhanced_feature_control[c][3:0] == 4'h0) begin
        st_nxt.tx_paused[c] = 1'b0;
      end else if (m_pause[c]) begin
        st_nxt.tx_paused[c] = 1'b1;
      end else if (m_resume[c]) begin
        st_nxt.tx_paused[c] = 1'b0;
      end
      ev[uef_pkg::UEF_EV_SPECIAL + c] = m_special[c];
      ev[uef_pkg::UEF_EV_PAUSE + c] = m_pause[c];
      ev[uef_pkg::UEF_EV_RESUME + c] = m_resume[c];
      st_nxt.lsr65[c] = {i_tsr_empty[c], i_thr_empty[c]};
      st_nxt.lsr0[c] = i_rx_has_data[c];
      // the character still goes to the fifo whatever the comparators decide
      st_nxt.rx_store[c] = i_rx_valid[c];
      st_nxt.rx_data[c] = i_rx_data[c];
      st_nxt.ser[c] = i_tx_bit[c] & ~st_r.line_control_reg[c][uef_pkg::UEF_LCR_BREAK];
      st_nxt.rts_n[c] = ~st_r.modem_control_reg[c][uef_pkg::UEF_MCR_RTS];
      st_nxt.dtr_n[c] = ~st_r.modem_control_reg[c][uef_pkg::UEF_MCR_DTR];
    end
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
    st_nxt.receive_dma_ready_n = ~|i_rx_has_data;
    st_nxt.transmit_dma_ready_n = |i_tx_fifo_full;

    if (i_srst) begin
      st_nxt = '0;
      for (int c = 0; c < NCH; c++) begin
        st_nxt.interrupt_enable_reg[c] = uef_pkg::UEF_RST_CTRL;
        st_nxt.line_control_reg[c] = uef_pkg::UEF_RST_CTRL;
        st_nxt.modem_control_reg[c] = uef_pkg::UEF_RST_CTRL;
        st_nxt.fifo_control_reg[c] = uef_pkg::UEF_RST_CTRL;
        st_nxt.enhanced_feature_control[c] = uef_pkg::UEF_RST_CTRL;
        st_nxt.isr54[c] = uef_pkg::UEF_RST_ISR[5:4];
        st_nxt.lsr65[c] = uef_pkg::UEF_RST_LSR[6:5];
        st_nxt.lsr0[c] = uef_pkg::UEF_RST_LSR[0];
        st_nxt.msr_delta[c] = uef_pkg::UEF_RST_MSR_DELTA;
      end
      st_nxt.ser = 4'hf;
      st_nxt.rts_n = 4'hf;
      st_nxt.dtr_n = 4'hf;
      st_nxt.receive_dma_ready_n = 1'b1;
      st_nxt.transmit_dma_ready_n = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = !st_r.wait_n;
  assign o_irq = st_r.irq;
  assign o_rx_store = st_r.rx_store;
  assign o_rx_data = st_r.rx_data;
  assign o_tx_paused = st_r.tx_paused;
  assign o_serial_out = st_r.ser;
  assign o_request_send_n = st_r.rts_n;
  assign o_terminal_ready_n = st_r.dtr_n;
  assign o_receive_dma_ready_n = st_r.receive_dma_ready_n;
  assign o_transmit_dma_ready_n = st_r.transmit_dma_ready_n;
  for (genvar c = 0; c < NCH; c++) begin : g_sel
    assign o_tx_flow_sel[c] = st_r.enhanced_feature_control[c][3:2];
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic wr_go;
  assign wr_go = i_avs_write && !o_avs_waitrequest;

  reset_ctrl_a: assert property (@(posedge i_clk)
    $fell(i_srst) |-> st_r.interrupt_enable_reg == '0 && st_r.line_control_reg == '0 && st_r.modem_control_reg == '0
      && st_r.fifo_control_reg == '0 && st_r.enhanced_feature_control == '0)
    else $error("control registers not cleared by reset");

  reset_isr_a: assert property (@(posedge i_clk)
    $fell(i_srst) |-> st_r.isr54 == '0)
    else $error("status bits not cleared by reset");

  reset_lsr_a: assert property (@(posedge i_clk)
    $fell(i_srst) |-> st_r.lsr65 == 8'hff && st_r.lsr0 == 4'h0)
    else $error("line status reset value wrong");

  reset_msr_a: assert property (@(posedge i_clk)
    $fell(i_srst) |-> st_r.msr_delta == '0)
    else $error("modem change bits not cleared by reset");

  reset_pins_a: assert property (@(posedge i_clk)
    i_srst ##1 i_srst |-> o_serial_out == 4'hf && o_request_send_n == 4'hf
      && o_terminal_ready_n == 4'hf && o_receive_dma_ready_n && !o_transmit_dma_ready_n)
    else $error("output pins wrong during reset");

  ier_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_go && i_avs_address == 9'h040 && !st_r.enhanced_feature_control[1][4]
      |=> st_r.interrupt_enable_reg[1][7:4] == $past(st_r.interrupt_enable_reg[1][7:4]))
    else $error("upper enable bits written while locked");

  mcr_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_go && i_avs_address == 9'h050 && st_r.enhanced_feature_control[1][4]
      |=> st_r.modem_control_reg[1][6] == $past(i_avs_writedata[6]))
    else $error("modem control bit six not taken while unlocked");

  special_isr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    m_special[1] |=> st_r.isr54[1][0] ##1 o_avs_waitrequest || !i_avs_read || st_r.isr54[1][0])
    else $error("special character status not set");

  tx_sel_a: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_go && i_avs_address == 9'h05c |=> o_tx_flow_sel[1] == $past(i_avs_writedata[3:2]))
    else $error("transmit selection does not follow bits three and two");

  chan_indep_a: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_go && i_avs_address == 9'h05c |=> st_r.enhanced_feature_control[0] == $past(st_r.enhanced_feature_control[0]))
    else $error("channel one write disturbed channel zero");

  bus_wait_c: cover property (@(posedge i_clk) disable iff (i_srst)
    i_avs_read && o_avs_waitrequest ##1 !o_avs_waitrequest);
  irq_c: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_irq));
  paused_c: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_tx_paused[1]));

endmodule : uef_top

/* testbench/uef_remote.sv */
// Purpose: remote serial device model that hands received characters to the block
// Assumes: one character per cycle of i_go, characters may run back to back
// Notes: outside a character the data bus shows the inverted byte, so stale data never matches
`timescale 1ns/1ps
module uef_remote (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_char,
  output logic o_valid,
  output logic [7:0] o_data
);
  always_ff @(posedge i_clk) begin
    o_valid <= i_go;
    o_data <= i_go ? i_char : ~i_char;
  end
endmodule : uef_remote

/* testbench/uef_top_tb.sv */
// Purpose: self-checking bench for the enhanced flow and reset block
// Assumes: one remote model shared by all channels through a channel select
// Notes: random bytes from a fixed-seed xorshift; expectations come from bench functions
`timescale 1ns/1ps
module uef_top_tb;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [8:0] av_a = 9'h000;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_d = 32'h0000_0000;
  logic [31:0] o_avs_readdata, q;
  logic o_avs_waitrequest, o_irq, o_receive_dma_ready_n, o_transmit_dma_ready_n, pv;
  logic [3:0] o_rx_store, o_tx_paused, o_serial_out, o_request_send_n, o_terminal_ready_n;
  logic [3:0][1:0] o_tx_flow_sel;
  logic [3:0] tx_bit = 4'h0;
  logic [3:0] has_data = 4'hf;
  logic [3:0] fifo_full = 4'hf;
  logic [3:0][3:0] modem_n = 16'h5a3c;
  logic rgo = 1'b0;
  logic [7:0] rc = 8'h00;
  logic [7:0] pd;
  logic [7:0] pdq;
  logic [3:0][7:0] rxd;
  logic [1:0] rch = 2'h0;
  logic [31:0] seed = 32'h0000_002f;
  int miscompares = 0;
  int checks = 0;
  int nstore = 0;
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  uef_remote u_uef_remote (.i_clk(i_clk), .i_go(rgo), .i_char(rc), .o_valid(pv), .o_data(pd));
  uef_top u_uef_top (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(av_a), .i_avs_read(av_r),
    .i_avs_write(av_w), .i_avs_writedata(av_d), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .i_rx_valid(4'(pv) << rch),
    .i_rx_data({4{pd}}), .o_rx_store(o_rx_store), .o_rx_data(rxd), .o_tx_flow_sel(o_tx_flow_sel),
    .o_tx_paused(o_tx_paused), .i_tx_bit(tx_bit), .i_thr_empty(4'hf), .i_tsr_empty(4'hf),
    .i_rx_has_data(has_data), .i_tx_fifo_full(fifo_full), .i_modem_n(modem_n),
    .o_serial_out(o_serial_out), .o_request_send_n(o_request_send_n),
    .o_terminal_ready_n(o_terminal_ready_n), .o_receive_dma_ready_n(o_receive_dma_ready_n),
    .o_transmit_dma_ready_n(o_transmit_dma_ready_n));
  always @(posedge i_clk) nstore <= nstore + $countones(o_rx_store);
  always @(posedge i_clk) begin
    pdq <= pd;
    if (o_rx_store[rch]) chk(rxd[rch], {24'h00_0000, pdq}, "rx data");
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  function automatic logic [8:0] ra(input logic [1:0] ch, input logic [3:0] idx);
    return {1'b0, ch, idx, 2'b00};
  endfunction : ra
  function automatic logic [31:0] rst_val(input logic [3:0] idx, input logic [3:0] pins);
    case (idx)
      uef_pkg::UEF_IDX_ISR: return 32'h0000_0001;
      uef_pkg::UEF_IDX_LSR: return 32'h0000_0060;
      uef_pkg::UEF_IDX_MSR: return {24'h00_0000, ~pins, 4'h0};
      default: return 32'h0000_0000;
    endcase
  endfunction : rst_val
  // ring indicator flags only when its pin rises; the other pins flag any change
  function automatic logic [7:0] msr_exp(input logic [3:0] po, input logic [3:0] pn);
    return {~pn, po[3] ^ pn[3], ~po[2] & pn[2], po[1:0] ^ pn[1:0]};
  endfunction : msr_exp
  function automatic logic [31:0] gate(input logic [7:0] old, input logic [7:0] nw);
    return {24'h00_0000, old[7:4], nw[3:0]};
  endfunction : gate
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    av_a <= a;
    av_d <= d;
    av_w <= w;
    av_r <= ~w;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e, s);
  endtask : rd
  task automatic snd(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] b, input int n);
    rch <= ch;
    rgo <= 1'b1;
    rc <= a;
    @(posedge i_clk);
    if (n == 2) begin
      rc <= b;
      @(posedge i_clk);
    end
    rgo <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : snd
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    logic [1:0] c;
    logic [7:0] b, ex;
    int s0;
    repeat (15) @(posedge i_clk);
    chk({o_serial_out, o_request_send_n, o_terminal_ready_n}, 32'h0000_0fff, "pins");
    chk({o_receive_dma_ready_n, o_transmit_dma_ready_n}, 32'h0000_0002, "dma");
    @(posedge i_clk);
    i_srst <= 1'b0;
    tx_bit <= 4'hf;
    has_data <= 4'h0;
    fifo_full <= 4'h0;
    @(posedge i_clk);
    for (int ch = 0; ch < 4; ch++) begin
      for (int i = 0; i < 8; i++) rd(ra(2'(ch), 4'(i)), rst_val(4'(i), modem_n[ch]), "rst");
    end
    chk({o_serial_out, o_request_send_n, o_terminal_ready_n}, 32'h0000_0fff, "pins after");
    chk({o_receive_dma_ready_n, o_transmit_dma_ready_n}, 32'h0000_0002, "dma after");
    rd(9'h1fc, 32'h0000_0000, "unmapped");
    b = rnd8();
    c = b[1:0];
    // move the modem pins of one channel and read the live levels and change bits
    ex = msr_exp(modem_n[c], b[7:4]);
    modem_n[c] <= b[7:4];
    @(posedge i_clk);
    rd(ra(c, 4'h6), {24'h00_0000, ex}, "msr live");
    wr(ra(c, 4'h0), 32'h0000_00f5);
    rd(ra(c, 4'h0), gate(8'h00, 8'hf5), "ier locked");
    wr(ra(c, 4'h7), 32'h0000_0010);
    wr(ra(c, 4'h0), 32'h0000_00f5);
    wr(ra(c, 4'h4), 32'h0000_0040);
    rd(ra(c, 4'h0), 32'h0000_00f5, "ier open");
    wr(ra(c, 4'h7), 32'h0000_0000);
    wr(ra(c, 4'h0), 32'h0000_000a);
    wr(ra(c, 4'h4), 32'h0000_0003);
    rd(ra(c, 4'h0), gate(8'hf5, 8'h0a), "ier latched");
    rd(ra(c, 4'h4), 32'h0000_0043, "mcr latched");
    // special character on the pause_char_second register, interrupt enabled then masked
    wr(ra(c, 4'hb), {24'h00_0000, b});
    wr(ra(c, 4'h7), 32'h0000_0020);
    wr(9'h108, 32'h0000_0001 << c);
    s0 = nstore;
    snd(c, b ^ 8'h01, 8'h00, 1);
    rd(ra(c, 4'h1), 32'h0000_0001, "bit zero");
    snd(c, b, 8'h00, 1);
    chk(nstore - s0, 2, "stored");
    chk(o_irq, 1, "irq up");
    rd(9'h100, 32'h0000_0001 << c, "status");
    rd(ra(c, 4'h1), 32'h0000_0010, "special");
    wr(9'h104, 32'h0000_0001 << c);
    wr(9'h108, 32'h0000_0000);
    snd(c, b, 8'h00, 1);
    chk(o_irq, 0, "masked");
    rd(9'h100, 32'h0000_0001 << c, "masked status");
    b = rnd8();
    c = b[1:0];
    for (int i = 0; i < 4; i++) wr(ra(c, 4'(8 + i)), {24'h00_0000, b ^ (8'h01 << i)});
    for (int m = 0; m < 4; m++) begin
      ex = rnd8();
      wr(ra(c, 4'h7), {24'h00_0000, 4'h0, ex[3:2], 2'(m)});
      snd(c, b ^ (m == 1 ? 8'h08 : 8'h04), b ^ 8'h08, m == 3 ? 2 : 1);
      chk(o_tx_flow_sel[c], ex[3:2], "tx select");
      chk(o_tx_paused, 32'(m != 0) << c, "paused");
      snd(c, b ^ (m == 1 ? 8'h02 : 8'h01), b ^ 8'h02, m == 3 ? 2 : 1);
      chk(o_tx_paused, 0, "resumed");
    end
    give_verdict();
  end
endmodule : uef_top_tb
